// *** core/obag_core.sv ***
// Address generation, branch target and operand datapath slice with register files.
`timescale 1ns/1ps
// Overview of operation
// - Immediate indexed address is base register plus instruction displacement.
// - Register indexed address is base register plus second register.
// - Register indirect address is the base register unchanged.
// - Update forms write the computed address back into the base register.
// - Sequential flow advances the instruction address by four bytes.
// - Relative branch adds the supplied displacement to the present address.
// - Absolute branch takes the supplied value as target.
// - Return-address branch takes the return address register contents.
// - Loop-count branch takes the loop count register contents.
// - Byte, halfword and word operands, signed two's complement or unsigned.
// - Multi-byte operands are addressed by their lowest byte address.
// - Big-endian and little-endian byte orders are both supported.
// - Thirty-two 32-bit general registers, usable at every privilege level.
// - Privileged mode reaches everything; user mode is denied a subset.
// - Special registers are 32-bit; only return and loop registers are user accessible.
// - Multiply finishes in four cycles, divide in thirty-five cycles.
// - Untranslated addresses go out physical; translated ones are marked for translation.
// - Unaligned loads and stores are accepted.
module obag_core
  import obag_pkg::*;
#(
  parameter int XLEN = OBAG_XLEN,
  parameter int NREG = OBAG_NREG
)
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic user_mode_i,
  input wire logic translate_i,
  input wire logic big_endian_i,
  input wire obag_pkg::obag_mem_req_t mem_req_i,
  input wire logic [31:0] load_data_i,
  input wire logic load_valid_i,
  input wire obag_pkg::obag_br_req_t br_req_i,
  input wire obag_pkg::obag_spr_req_t spr_req_i,
  input wire obag_pkg::obag_au_req_t au_req_i,
  output obag_pkg::obag_mem_port_t mem_port_o,
  output logic [31:0] next_pc_o,
  output logic [31:0] spr_rdata_o,
  output logic priv_fault_o,
  output logic au_busy_o,
  output logic au_done_o
);
  import obag_pkg::*;

  // Register storage.
  logic [XLEN-1:0] gpr_reg [NREG];
  logic [XLEN-1:0] spr_reg [OBAG_NSPR];
  logic [31:0] pc_reg;
  obag_mem_port_t port_reg;
  logic [4:0] load_dst_reg;
  obag_size_t load_size_reg;
  logic load_sext_reg;
  logic [31:0] spr_rdata_reg;
  logic fault_reg;

  // Operand reads.
  wire logic [31:0] base_val = gpr_reg[mem_req_i.base_sel];
  wire logic [31:0] index_val = gpr_reg[mem_req_i.index_sel];
  wire logic [31:0] store_val = gpr_reg[mem_req_i.data_sel];

  // Effective address selection.
  wire logic [31:0] ea_imm = base_val + mem_req_i.disp;
  wire logic [31:0] ea_reg = base_val + index_val;
  wire logic [31:0] ea = (mem_req_i.mode == OBAG_AM_IMM) ? ea_imm :
                         (mem_req_i.mode == OBAG_AM_REG) ? ea_reg : base_val;
  wire logic do_update = mem_req_i.valid && mem_req_i.update && (mem_req_i.mode != OBAG_AM_IND);

  // Store data in memory byte order; lane 0 is the lowest address, no alignment check is made.
  wire logic [31:0] st_le = (mem_req_i.size == OBAG_SZ_BYTE) ? {24'h000000, store_val[7:0]} :
                            (mem_req_i.size == OBAG_SZ_HALF) ? {16'h0000, store_val[15:0]} : store_val;
  wire logic [31:0] st_be = (mem_req_i.size == OBAG_SZ_BYTE) ? {24'h000000, store_val[7:0]} :
                            (mem_req_i.size == OBAG_SZ_HALF) ? {16'h0000, store_val[7:0], store_val[15:8]} :
                            {store_val[7:0], store_val[15:8], store_val[23:16], store_val[31:24]};
  wire logic [31:0] st_data = big_endian_i ? st_be : st_le;

  // Load data from memory byte order back into a register value.
  wire logic [31:0] ld_be = {load_data_i[7:0], load_data_i[15:8], load_data_i[23:16], load_data_i[31:24]};
  wire logic [31:0] ld_swap = (load_size_reg == OBAG_SZ_HALF) ? {16'h0000, load_data_i[7:0], load_data_i[15:8]} : ld_be;
  wire logic [31:0] ld_raw = (big_endian_i && load_size_reg != OBAG_SZ_BYTE) ? ld_swap : load_data_i;
  wire logic [31:0] ld_val = (load_size_reg == OBAG_SZ_BYTE) ?
                             {{24{load_sext_reg & ld_raw[7]}}, ld_raw[7:0]} :
                             (load_size_reg == OBAG_SZ_HALF) ?
                             {{16{load_sext_reg & ld_raw[15]}}, ld_raw[15:0]} : ld_raw;

  // Next instruction address selection.
  wire logic [31:0] pc_seq = pc_reg + OBAG_PC_STEP;
  wire logic [31:0] pc_rel = pc_reg + br_req_i.value;
  logic [31:0] pc_next;
  always_comb
  begin
    pc_next = pc_seq;
    if (br_req_i.valid)
    begin
      case (br_req_i.mode)
        OBAG_BR_REL: pc_next = pc_rel;
        OBAG_BR_ABS: pc_next = br_req_i.value;
        OBAG_BR_RET: pc_next = spr_reg[OBAG_SPR_RET];
        OBAG_BR_LOOP: pc_next = spr_reg[OBAG_SPR_LOOP];
        default: pc_next = pc_seq;
      endcase
    end
  end

  // Privilege check on special register access.
  wire logic spr_user_ok = (spr_req_i.sel == OBAG_SPR_RET) || (spr_req_i.sel == OBAG_SPR_LOOP);
  wire logic spr_denied = spr_req_i.valid && user_mode_i && !spr_user_ok;
  wire logic spr_go = spr_req_i.valid && !spr_denied;

  // Multiply and divide unit with fixed latency.
  obag_au_state_t au_state_reg;
  logic [5:0] au_cnt_reg;
  logic [5:0] au_last_reg;
  logic [4:0] au_dst_reg;
  logic [31:0] au_res_reg;
  wire logic [31:0] au_a = gpr_reg[au_req_i.a_sel];
  wire logic [31:0] au_b = gpr_reg[au_req_i.b_sel];
  wire logic au_start = au_req_i.valid && (au_state_reg != OBAG_AU_BUSY);
  wire logic a_neg = au_req_i.sign & au_a[31];
  wire logic b_neg = au_req_i.sign & au_b[31];
  wire logic [31:0] a_mag = a_neg ? (32'h0 - au_a) : au_a;
  wire logic [31:0] b_mag = b_neg ? (32'h0 - au_b) : au_b;
  wire logic [31:0] q_mag = (b_mag == 32'h0) ? 32'h0 : (a_mag / b_mag);
  wire logic [31:0] quot = (a_neg ^ b_neg) ? (32'h0 - q_mag) : q_mag;
  wire logic [31:0] prod = au_a * au_b;
  wire logic [31:0] au_val = au_req_i.divide ? quot : prod;
  wire logic au_fin = (au_state_reg == OBAG_AU_BUSY) && (au_cnt_reg == au_last_reg);

  // Arithmetic unit sequencing; the result is released after the full latency.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      au_state_reg <= OBAG_AU_IDLE;
      au_cnt_reg <= 6'h00;
      au_last_reg <= 6'h00;
      au_dst_reg <= 5'h00;
      au_res_reg <= OBAG_RESET_VALUE;
    end
    else if (ce_i)
    begin
      case (au_state_reg)
        OBAG_AU_IDLE, OBAG_AU_DONE:
        begin
          au_state_reg <= au_start ? OBAG_AU_BUSY : OBAG_AU_IDLE;
          au_cnt_reg <= 6'h01;
          if (au_start)
          begin
            au_last_reg <= au_req_i.divide ? OBAG_DIV_LAST : OBAG_MUL_LAST;
            au_dst_reg <= au_req_i.dst;
            au_res_reg <= au_val;
          end
        end
        OBAG_AU_BUSY:
        begin
          au_cnt_reg <= au_cnt_reg + 6'h01;
          if (au_fin)
            au_state_reg <= OBAG_AU_DONE;
        end
        default: au_state_reg <= OBAG_AU_IDLE;
      endcase
    end
  end

  // General register file writes; load return, address update and results share one cycle.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < NREG; i++)
        gpr_reg[i] <= OBAG_RESET_VALUE;
    end
    else if (ce_i)
    begin
      if (au_fin)
        gpr_reg[au_dst_reg] <= au_res_reg;
      if (spr_go && !spr_req_i.write)
        gpr_reg[spr_req_i.reg_sel] <= spr_reg[spr_req_i.sel];
      if (do_update)
        gpr_reg[mem_req_i.base_sel] <= ea;
      if (load_valid_i)
        gpr_reg[load_dst_reg] <= ld_val;
    end
  end

  // Special register file; user-mode writes to privileged entries are dropped.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < OBAG_NSPR; i++)
        spr_reg[i] <= OBAG_RESET_VALUE;
      spr_rdata_reg <= OBAG_RESET_VALUE;
      fault_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (spr_go && spr_req_i.write)
        spr_reg[spr_req_i.sel] <= gpr_reg[spr_req_i.reg_sel];
      if (spr_go)
        spr_rdata_reg <= spr_reg[spr_req_i.sel];
      fault_reg <= spr_denied;
    end
  end

  // Memory port, program counter and pending load tracking.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      port_reg <= '0;
      pc_reg <= OBAG_PC_RESET;
      load_dst_reg <= 5'h00;
      load_size_reg <= OBAG_SZ_WORD;
      load_sext_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      pc_reg <= pc_next;
      port_reg.valid <= mem_req_i.valid;
      port_reg.store <= mem_req_i.store;
      port_reg.translate <= translate_i;
      port_reg.size <= mem_req_i.size;
      port_reg.addr <= ea;
      port_reg.wdata <= st_data;
      if (mem_req_i.valid && !mem_req_i.store)
      begin
        load_dst_reg <= mem_req_i.data_sel;
        load_size_reg <= mem_req_i.size;
        load_sext_reg <= mem_req_i.sign_ext;
      end
    end
  end

  assign mem_port_o = port_reg;
  assign next_pc_o = pc_reg;
  assign spr_rdata_o = spr_rdata_reg;
  assign priv_fault_o = fault_reg;
  assign au_busy_o = (au_state_reg == OBAG_AU_BUSY);
  assign au_done_o = (au_state_reg == OBAG_AU_DONE);

endmodule

// *** core/obag_pkg.sv ***
// Package with constants, enumerations and carrier structs for the address and operand datapath.
package obag_pkg;

  localparam int OBAG_XLEN = 32;
  localparam int OBAG_NREG = 32;
  localparam logic [31:0] OBAG_PC_STEP = 32'h0000_0004;
  localparam logic [31:0] OBAG_RESET_VALUE = 32'h0000_0000;
  localparam logic [31:0] OBAG_PC_RESET = 32'h0000_0000;
  // Latencies in cycles of the arithmetic units.
  localparam int OBAG_MUL_CYCLES = 4;
  localparam int OBAG_DIV_CYCLES = 35;
  localparam logic [5:0] OBAG_MUL_LAST = 6'h04;
  localparam logic [5:0] OBAG_DIV_LAST = 6'h23;
  // Special register selectors.
  localparam logic [3:0] OBAG_SPR_RET = 4'h0;
  localparam logic [3:0] OBAG_SPR_LOOP = 4'h1;
  localparam int OBAG_NSPR = 16;

  typedef enum logic [1:0] {
    OBAG_AM_IMM = 2'h0,
    OBAG_AM_REG = 2'h1,
    OBAG_AM_IND = 2'h2
  } obag_amode_t;

  typedef enum logic [2:0] {
    OBAG_BR_SEQ = 3'h0,
    OBAG_BR_REL = 3'h1,
    OBAG_BR_ABS = 3'h2,
    OBAG_BR_RET = 3'h3,
    OBAG_BR_LOOP = 3'h4
  } obag_bmode_t;

  typedef enum logic [1:0] {
    OBAG_SZ_BYTE = 2'h0,
    OBAG_SZ_HALF = 2'h1,
    OBAG_SZ_WORD = 2'h2
  } obag_size_t;

  // Arithmetic unit state, Gray coded along idle, busy, done.
  typedef enum logic [1:0] {
    OBAG_AU_IDLE = 2'b00,
    OBAG_AU_BUSY = 2'b01,
    OBAG_AU_DONE = 2'b11
  } obag_au_state_t;

  // Load or store request from decode.
  typedef struct packed {
    logic valid;
    logic store;
    logic update;
    logic sign_ext;
    obag_amode_t mode;
    obag_size_t size;
    logic [4:0] base_sel;
    logic [4:0] index_sel;
    logic [4:0] data_sel;
    logic [31:0] disp;
  } obag_mem_req_t;

  // Request to the memory port.
  typedef struct packed {
    logic valid;
    logic store;
    logic translate;
    obag_size_t size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } obag_mem_port_t;

  // Branch request from decode.
  typedef struct packed {
    logic valid;
    obag_bmode_t mode;
    logic [31:0] value;
  } obag_br_req_t;

  // Special register access from decode.
  typedef struct packed {
    logic valid;
    logic write;
    logic [3:0] sel;
    logic [4:0] reg_sel;
  } obag_spr_req_t;

  // Multiply or divide request.
  typedef struct packed {
    logic valid;
    logic divide;
    logic sign;
    logic [4:0] a_sel;
    logic [4:0] b_sel;
    logic [4:0] dst;
  } obag_au_req_t;

endpackage

// *** test/obag_asserts.sv ***
// Concurrent checks on the ports of the datapath slice.
`timescale 1ns/1ps
module obag_asserts
  import obag_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  input wire logic user_mode_i,
  input wire logic translate_i,
  input wire obag_pkg::obag_mem_req_t mem_req_i,
  input wire obag_pkg::obag_br_req_t br_req_i,
  input wire obag_pkg::obag_spr_req_t spr_req_i,
  input wire obag_pkg::obag_au_req_t au_req_i,
  input wire obag_pkg::obag_mem_port_t mem_port_o,
  input wire logic [31:0] next_pc_o,
  input wire logic priv_fault_o,
  input wire logic au_busy_o,
  input wire logic au_done_o
);
  // Every check runs on the core clock and rests while reset is high.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Requests that the core takes on this edge.
  wire logic br = ce_i && br_req_i.valid;
  wire logic mr = ce_i && mem_req_i.valid;
  wire logic au = ce_i && au_req_i.valid && !au_busy_o;
  wire logic deny = ce_i && spr_req_i.valid && user_mode_i && spr_req_i.sel > OBAG_SPR_LOOP;
  a_seq_step: assert property (br && br_req_i.mode == OBAG_BR_SEQ |=> next_pc_o == $past(next_pc_o) + OBAG_PC_STEP)
    else $error("sequential step wrong");
  a_rel_target: assert property (br && br_req_i.mode == OBAG_BR_REL |=> next_pc_o == $past(next_pc_o) + $past(br_req_i.value))
    else $error("relative target wrong");
  a_abs_target: assert property (br && br_req_i.mode == OBAG_BR_ABS |=> next_pc_o == $past(br_req_i.value))
    else $error("absolute target wrong");
  a_port_kind: assert property (mr |=> mem_port_o.valid && mem_port_o.store == $past(mem_req_i.store) && mem_port_o.size == $past(mem_req_i.size))
    else $error("memory port request wrong");
  a_xlat_flag: assert property (mr |=> mem_port_o.translate == $past(translate_i))
    else $error("translate flag wrong");
  a_mul_time: assert property (au && !au_req_i.divide |=> (au_busy_o && !au_done_o) [*4] ##1 au_done_o)
    else $error("multiply latency wrong");
  a_div_time: assert property (au && au_req_i.divide |-> ##35 (au_busy_o && !au_done_o) ##1 au_done_o)
    else $error("divide latency wrong");
  a_fault_raise: assert property (deny |=> priv_fault_o)
    else $error("denied access not flagged");
  a_fault_quiet: assert property (!deny |=> !priv_fault_o)
    else $error("fault without denied access");
endmodule
bind obag_core obag_asserts u_chk (.*);

// *** test/obag_mem_model.sv ***
// Behavioural memory on the far side of the load and store port.
`timescale 1ns/1ps
module obag_mem_model
  import obag_pkg::*;
(
  input wire logic clk_i,
  input wire obag_pkg::obag_mem_port_t port_i,
  input wire logic slow_i,
  output logic [31:0] data_o,
  output logic valid_o
);
  logic [7:0] mem [logic [31:0]];
  logic [31:0] a;
  int w = -1;
  // Bytes never stored read back as a pattern of their address.
  function automatic logic [7:0] rd(logic [31:0] x);
    return mem.exists(x) ? mem[x] : x[7:0] ^ 8'ha5;
  endfunction
  initial
  begin
    data_o = '0;
    valid_o = 1'b0;
  end
  // Lane 0 is the lowest byte address; the data line toggles when nothing is returned.
  always @(posedge clk_i)
  begin
    valid_o <= 1'b0;
    data_o <= ~data_o;
    if (w == 0)
    begin
      valid_o <= 1'b1;
      data_o <= {rd(a + 3), rd(a + 2), rd(a + 1), rd(a)};
    end
    if (w >= 0) w <= w - 1;
    if (port_i.valid && port_i.store)
      for (int i = 0; i < (1 << port_i.size); i++) mem[port_i.addr + i] = port_i.wdata[8*i +: 8];
    if (port_i.valid && !port_i.store)
    begin
      a <= port_i.addr;
      w <= slow_i ? 3 : 0;
    end
  end
endmodule

// *** test/operand_branch_address_gen_tb.sv ***
// Self-checking bench for the address and operand datapath slice.
`timescale 1ns/1ps
module operand_branch_address_gen_tb;
  import obag_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic user_mode_i = 1'b0;
  logic translate_i = 1'b0;
  logic big_endian_i = 1'b0;
  logic slow = 1'b0;
  logic ce = 1'b1;
  obag_mem_req_t mem_req_i = '0;
  obag_br_req_t br_req_i = '0;
  obag_spr_req_t spr_req_i = '0;
  obag_au_req_t au_req_i = '0;
  obag_mem_port_t mem_port_o;
  logic [31:0] load_data_i, next_pc_o, spr_rdata_o, pc;
  logic load_valid_i, priv_fault_o, au_busy_o, au_done_o;
  logic [31:0] g [32];
  logic [31:0] sr [16];
  logic [7:0] m [logic [31:0]];
  int n_errors = 0;
  int comparisons = 0;
  int seed = 13178;
  int k, d, b, x;
  // The core clock toggles every half period.
  always #5 clk_i = ~clk_i;
  obag_core u_dut (.ce_i(ce), .*);
  obag_mem_model u_mem (.clk_i, .port_i(mem_port_o), .slow_i(slow), .data_o(load_data_i), .valid_o(load_valid_i));
  task automatic test_done(int late);
    n_errors += late;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(string s, logic [31:0] e, logic [31:0] v);
    comparisons++;
    if (v !== e)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, v);
    end
  endtask
  function automatic logic [7:0] mb(logic [31:0] a);
    return m.exists(a) ? m[a] : a[7:0] ^ 8'ha5;
  endfunction
  // One load or store; the model tracks registers, memory and base updates.
  task automatic mo(logic st, logic up, obag_amode_t md, obag_size_t sz, int r, logic [31:0] dp, logic se);
    logic [31:0] ea, e;
    int n, j;
    n = 1 << sz;
    @(posedge clk_i);
    mem_req_i <= '{1'b1, st, up, se, md, sz, 5'(b), 5'(x), 5'(r), dp};
    translate_i <= $random(seed);
    ea = md == OBAG_AM_IND ? g[b] : g[b] + (md == OBAG_AM_IMM ? dp : g[x]);
    e = '0;
    for (int i = 0; i < n; i++)
    begin
      j = big_endian_i ? n - 1 - i : i;
      if (st) e[8*i +: 8] = g[r][8*j +: 8];
      else e[8*j +: 8] = mb(ea + i);
      if (st) m[ea + i] = e[8*i +: 8];
    end
    if (se && !st && e[8*n-1]) e = e | (32'hffffffff << 8*n);
    if (up && md != OBAG_AM_IND) g[b] = ea;
    @(posedge clk_i);
    mem_req_i <= '0;
    #1;
    chk("addr", ea, mem_port_o.addr);
    chk("xlat", 32'(translate_i), 32'(mem_port_o.translate));
    if (st) chk("wdata", e, mem_port_o.wdata & (32'hffffffff >> (32 - 8*n)));
    for (k = 0; k < 20 && !st && !load_valid_i; k++) @(posedge clk_i) #1;
    if (k == 20) test_done(1);
    if (!st) @(posedge clk_i) g[r] = e;
  endtask
  // One multiply or divide from registers b and x into r.
  task automatic au(logic dv, logic sg, int r);
    logic [31:0] e;
    @(posedge clk_i);
    au_req_i <= '{1'b1, dv, sg, 5'(b), 5'(x), 5'(r)};
    e = g[b] * g[x];
    if (dv) e = '0;
    if (dv && g[x] != 0 && sg) e = $signed(g[b]) / $signed(g[x]);
    if (dv && g[x] != 0 && !sg) e = g[b] / g[x];
    @(posedge clk_i);
    au_req_i <= '0;
    #1;
    for (k = 0; k < 40 && !au_done_o; k++) @(posedge clk_i) #1;
    if (k == 40) test_done(1);
    chk("latency", dv ? 35 : 4, k);
    g[r] = e;
  endtask
  // One special register move, with the privilege check applied.
  task automatic sp(logic w, logic [3:0] s, int r, logic u);
    logic ok;
    @(posedge clk_i);
    user_mode_i <= u;
    spr_req_i <= '{1'b1, w, s, 5'(r)};
    @(posedge clk_i);
    spr_req_i <= '0;
    #1;
    ok = !u || s <= OBAG_SPR_LOOP;
    chk("fault", 32'(!ok), 32'(priv_fault_o));
    if (ok && w) sr[s] = g[r];
    if (ok && !w) g[r] = sr[s];
    if (ok && !w) chk("spr read", sr[s], spr_rdata_o);
  endtask
  // One branch, followed by a held sequential step request.
  task automatic br(obag_bmode_t md, logic [31:0] v);
    logic [31:0] e;
    @(posedge clk_i);
    br_req_i <= '{1'b1, md, v};
    e = md == OBAG_BR_SEQ ? pc + 4 : md == OBAG_BR_REL ? pc + v : md == OBAG_BR_ABS ? v : sr[md - 3];
    @(posedge clk_i);
    br_req_i <= '{1'b1, OBAG_BR_SEQ, 32'h0};
    #1;
    chk("next pc", e, next_pc_o);
    pc = e + 4;
  endtask
  // Main sequence: random loads, arithmetic and stores, then special registers and branches.
  initial
  begin
    for (int i = 0; i < 32; i++) g[i] = '0;
    for (int i = 0; i < 16; i++) sr[i] = '0;
    repeat (16) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int t = 0; t < 48; t++)
    begin
      d = 1 + {$random(seed)} % 31;
      b = {$random(seed)} % 32;
      x = {$random(seed)} % 32;
      if (b == d) b = 0;
      big_endian_i <= $random(seed);
      user_mode_i <= $random(seed);
      slow <= $random(seed);
      mo(0, $random(seed), obag_amode_t'(t % 3), obag_size_t'(t / 3 % 3), d, $random(seed), $random(seed));
      if (t % 4 == 0) au(t[2], $random(seed), d);
      mo(1, 0, OBAG_AM_IND, obag_size_t'(t % 3), d, '0, 1'b0);
    end
    for (int s = 0; s < 4; s++)
    begin
      sp(1'b1, 4'(s), s + 1, s[0]);
      sp(1'b0, 4'(s), 20 + s, s == 2);
      d = 20 + s;
      b = 0;
      mo(1, 0, OBAG_AM_IND, OBAG_SZ_WORD, d, '0, 1'b0);
    end
    // With the clock enable low the instruction address must not move.
    @(posedge clk_i);
    ce <= 1'b0;
    #1;
    pc = next_pc_o;
    repeat (3) @(posedge clk_i);
    ce <= 1'b1;
    #1;
    chk("frozen pc", pc, next_pc_o);
    br(OBAG_BR_ABS, $random(seed));
    for (int i = 0; i < 5; i++) br(obag_bmode_t'(i), $random(seed));
    test_done(0);
  end
endmodule
